// >>> src/cau_pkg.sv
// Purpose: constants, operation codes and states of the core ALU and port unit
// Assumes: 8-bit accumulator and B, four 8-bit ports, one clock
// Notes: a port byte index is port number times eight
//
// Notes on behaviour
// - Port-destined read-modify-write ops take the operand from the output latch.
// - Pure port input ops sample the synchronised pin level, not the latch.
// - Carry-to-bit, clear-bit, set-bit rewrite the whole port byte, one bit changed.
// - AND, OR, XOR, jump-set-clear, complement, inc, dec, dec-jump read the latch.
// - Add and add-with-carry set carry on carry out of bit 7.
// - Add overflow is carry out of bit 6 XOR carry out of bit 7.
// - Add auxiliary carry is the carry out of bit 3.
// - Add-with-carry includes the carry flag; plain add ignores it.
// - Subtract-with-borrow takes source and carry from the accumulator.
// - Subtract carry shows a borrow needed into bit 7.
// - Subtract overflow shows a borrow for exactly one of bits 6 and 7.
// - Subtract auxiliary carry shows a borrow needed for bit 3.
// - Multiply: unsigned A times B, low byte to A, high byte to B.
// - Multiply clears carry; overflow set when product exceeds 255.
// - Divide: unsigned A over B, quotient to A, remainder to B.
// - Divide clears carry and overflow; zero divisor sets overflow instead.
// - Decimal adjust adds 0x06 when aux carry set or low nibble above 9.
// - Decimal adjust adds 0x60 when carry was set or low fix applied.
// - Decimal adjust sets carry when the adjusted result exceeds 0x99.
// - Rotate right through carry: bit 0 to carry, old carry to bit 7.
package cau_pkg;
    localparam int CAU_PIN_W = 32;
    localparam logic [7:0] CAU_PORT_RST = 8'hff;
    localparam logic [31:0] CAU_LATCH_RST = {4{CAU_PORT_RST}};
    localparam logic [7:0] CAU_BYTE_RST = 8'h00;
    localparam logic [3:0] CAU_DIV_STEPS = 4'h8;
    localparam logic [3:0] CAU_DIGIT_MAX = 4'h9;
    localparam logic [8:0] CAU_DA_LO = 9'h006;
    localparam logic [8:0] CAU_DA_HI = 9'h060;
    localparam logic [8:0] CAU_BCD_MAX = 9'h099;
    localparam logic [15:0] CAU_BYTE_MAX = 16'h00ff;

    typedef logic [4:0] cau_op_t;
    localparam cau_op_t CAU_ADD_OP = 5'h00;
    localparam cau_op_t CAU_ADD_WITH_CARRY_OP = 5'h01;
    localparam cau_op_t CAU_SUBTRACT_BORROW_OP = 5'h02;
    localparam cau_op_t CAU_MULTIPLY_OP = 5'h03;
    localparam cau_op_t CAU_DIVIDE_OP = 5'h04;
    localparam cau_op_t CAU_DECIMAL_ADJUST_OP = 5'h05;
    localparam cau_op_t CAU_ROTATE_RIGHT_CARRY_OP = 5'h06;
    localparam cau_op_t CAU_LOGICAL_AND_OP = 5'h07;
    localparam cau_op_t CAU_LOGICAL_OR_OP = 5'h08;
    localparam cau_op_t CAU_LOGICAL_XOR_OP = 5'h09;
    localparam cau_op_t CAU_INCREMENT_OP = 5'h0a;
    localparam cau_op_t CAU_DECREMENT_OP = 5'h0b;
    localparam cau_op_t CAU_DECREMENT_JUMP_NONZERO_OP = 5'h0c;
    localparam cau_op_t CAU_JUMP_SET_AND_CLEAR_OP = 5'h0d;
    localparam cau_op_t CAU_COMPLEMENT_OP = 5'h0e;
    localparam cau_op_t CAU_CLEAR_BIT_OP = 5'h0f;
    localparam cau_op_t CAU_SET_BIT_OP = 5'h10;
    localparam cau_op_t CAU_MOVE_CARRY_BIT_OP = 5'h11;
    localparam cau_op_t CAU_READ_PIN_BYTE_OP = 5'h12;
    localparam cau_op_t CAU_READ_PIN_BIT_OP = 5'h13;
    // Moves src_byte into B; without it multiply and divide only ever see B at zero
    localparam cau_op_t CAU_LOAD_B_OP = 5'h14;

    typedef enum logic [1:0] {
        CAU_ST_IDLE = 2'b01,
        CAU_ST_DIV = 2'b10
    } cau_state_t;
endpackage : cau_pkg

// >>> src/cau_pin_sync.sv
// Purpose: bring the port pins into the core clock domain
// Assumes: pins change asynchronously to sys_clk
// Notes: a bit changes only once the second and third stages agree
`timescale 1ns/1ps
module cau_pin_sync
    import cau_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [CAU_PIN_W-1:0] pin_in,
    output logic [CAU_PIN_W-1:0] pin_q
);
    logic [CAU_PIN_W-1:0] s1_q;
    logic [CAU_PIN_W-1:0] s2_q;
    logic [CAU_PIN_W-1:0] s3_q;
    wire [CAU_PIN_W-1:0] agree = ~(s2_q ^ s3_q);
    wire [CAU_PIN_W-1:0] pin_d = (agree & s2_q) | (~agree & pin_q);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s1_q <= CAU_LATCH_RST;
            s2_q <= CAU_LATCH_RST;
            s3_q <= CAU_LATCH_RST;
            pin_q <= CAU_LATCH_RST;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
        end
    end
endmodule : cau_pin_sync

// >>> src/cau_divider.sv
// Purpose: unsigned 8-bit restoring divider, one quotient bit per cycle
// Assumes: divisor is non-zero; the caller screens out zero
// Notes: done_q pulses on the same edge as the last step
`timescale 1ns/1ps
module cau_divider
    import cau_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [7:0] dividend,
    input wire logic [7:0] divisor,
    output logic done_q,
    output logic [7:0] quot_q,
    output logic [7:0] rem_q
);
    logic [3:0] cnt_q;
    logic [7:0] dvs_q;
    wire [8:0] trial = {rem_q, quot_q[7]};
    wire fits = trial >= {1'b0, dvs_q};
    wire [8:0] diff = trial - {1'b0, dvs_q};
    wire busy = cnt_q != 4'h0;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
            dvs_q <= CAU_BYTE_RST;
            quot_q <= CAU_BYTE_RST;
            rem_q <= CAU_BYTE_RST;
            done_q <= 1'b0;
        end else if (start) begin
            cnt_q <= CAU_DIV_STEPS;
            dvs_q <= divisor;
            quot_q <= dividend;
            rem_q <= CAU_BYTE_RST;
            done_q <= 1'b0;
        end else if (busy) begin
            cnt_q <= cnt_q - 4'h1;
            quot_q <= {quot_q[6:0], fits};
            rem_q <= fits ? diff[7:0] : trial[7:0];
            done_q <= cnt_q == 4'h1;
        end else begin
            done_q <= 1'b0;
        end
    end
endmodule : cau_divider

// >>> src/cau_alu_unit.sv
// Purpose: accumulator arithmetic, flags and port read-modify-write of the core
// Assumes: one operation offered at a time with op_valid while ready_q is high
// Notes: all ops finish in one cycle except divide by a non-zero divisor, which takes ten
`timescale 1ns/1ps
module cau_alu_unit
    import cau_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic [7:0] src_byte,
    input wire logic dst_port,
    input wire logic [1:0] port_sel,
    input wire logic [2:0] bit_sel,
    input wire logic [CAU_PIN_W-1:0] pin_in,
    output logic [7:0] acc_q,
    output logic [7:0] b_q,
    output logic carry_q,
    output logic aux_carry_flag_q,
    output logic overflow_flag_q,
    output logic [CAU_PIN_W-1:0] port_latch_q,
    output logic jump_q,
    output logic done_q,
    output logic ready_q
);
    // Returns {carry7, overflow, aux_carry, sum}
    function automatic logic [10:0] add_flags(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic ci
    );
        logic [4:0] lo;
        logic [7:0] mid;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        mid = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        add_flags = {full[8], full[8] ^ mid[7], lo[4], full[7:0]};
    endfunction : add_flags

    // Returns {borrow7, overflow, aux_borrow, difference}
    function automatic logic [10:0] sub_flags(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic bi
    );
        logic [4:0] lo;
        logic [7:0] mid;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bi};
        mid = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, bi};
        full = {1'b0, a} - {1'b0, b} - {8'h00, bi};
        sub_flags = {full[8], full[8] ^ mid[7], lo[4], full[7:0]};
    endfunction : sub_flags

    cau_state_t state_q;
    cau_state_t state_d;
    logic [CAU_PIN_W-1:0] pin_q;
    logic div_done;
    logic [7:0] div_quot;
    logic [7:0] div_rem;

    cau_pin_sync u_pin_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(pin_in),
        .pin_q(pin_q)
    );

    // Operand selection and decoding
    wire fire = op_valid && ready_q;
    wire [4:0] bit_idx = {port_sel, bit_sel};
    wire [7:0] latch_byte = port_latch_q[{port_sel, 3'h0} +: 8];
    wire [7:0] pin_byte = pin_q[{port_sel, 3'h0} +: 8];
    // Driving pins may sag a high output; the latch holds the intent
    wire [7:0] dst_byte = dst_port ? latch_byte : acc_q;
    wire [7:0] bit_mask = 8'h01 << bit_sel;
    wire dst_bit = dst_byte[bit_sel];
    wire pin_bit = pin_q[bit_idx];
    wire use_cin = op_code == CAU_ADD_WITH_CARRY_OP;
    wire [10:0] add_r = add_flags(acc_q, src_byte, use_cin && carry_q);
    wire [10:0] sub_r = sub_flags(acc_q, src_byte, carry_q);
    wire [15:0] prod = {8'h00, acc_q} * {8'h00, b_q};
    wire div_zero = b_q == CAU_BYTE_RST;
    wire lo_fix = aux_carry_flag_q || (acc_q[3:0] > CAU_DIGIT_MAX);
    wire hi_fix = carry_q || lo_fix;
    wire [8:0] da_lo = {1'b0, acc_q} + (lo_fix ? CAU_DA_LO : 9'h000);
    wire [8:0] da_sum = da_lo + (hi_fix ? CAU_DA_HI : 9'h000);
    wire [7:0] dec_byte = dst_byte - 8'h01;
    wire div_start = fire && (op_code == CAU_DIVIDE_OP) && !div_zero;

    cau_divider u_divider (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .start(div_start),
        .dividend(acc_q),
        .divisor(b_q),
        .done_q(div_done),
        .quot_q(div_quot),
        .rem_q(div_rem)
    );

    // Next values for one accepted operation
    logic [7:0] acc_d;
    logic [7:0] b_d;
    logic cy_d;
    logic ac_d;
    logic ov_d;
    logic [7:0] res_byte;
    logic res_valid;
    logic jump_d;

    always_comb begin
        acc_d = acc_q;
        b_d = b_q;
        cy_d = carry_q;
        ac_d = aux_carry_flag_q;
        ov_d = overflow_flag_q;
        res_byte = dst_byte;
        res_valid = 1'b0;
        jump_d = 1'b0;
        case (op_code)
            CAU_ADD_OP, CAU_ADD_WITH_CARRY_OP: begin
                acc_d = add_r[7:0];
                cy_d = add_r[10];
                ov_d = add_r[9];
                ac_d = add_r[8];
            end
            CAU_SUBTRACT_BORROW_OP: begin
                acc_d = sub_r[7:0];
                cy_d = sub_r[10];
                ov_d = sub_r[9];
                ac_d = sub_r[8];
            end
            CAU_MULTIPLY_OP: begin
                acc_d = prod[7:0];
                b_d = prod[15:8];
                cy_d = 1'b0;
                ov_d = prod > CAU_BYTE_MAX;
            end
            CAU_DIVIDE_OP: begin
                // Zero divisor leaves A and B as they were
                cy_d = 1'b0;
                ov_d = div_zero;
            end
            CAU_DECIMAL_ADJUST_OP: begin
                acc_d = da_sum[7:0];
                cy_d = da_sum > CAU_BCD_MAX;
            end
            CAU_ROTATE_RIGHT_CARRY_OP: begin
                acc_d = {carry_q, acc_q[7:1]};
                cy_d = acc_q[0];
            end
            CAU_LOGICAL_AND_OP: begin
                res_byte = dst_byte & src_byte;
                res_valid = 1'b1;
            end
            CAU_LOGICAL_OR_OP: begin
                res_byte = dst_byte | src_byte;
                res_valid = 1'b1;
            end
            CAU_LOGICAL_XOR_OP: begin
                res_byte = dst_byte ^ src_byte;
                res_valid = 1'b1;
            end
            CAU_INCREMENT_OP: begin
                res_byte = dst_byte + 8'h01;
                res_valid = 1'b1;
            end
            CAU_DECREMENT_OP: begin
                res_byte = dec_byte;
                res_valid = 1'b1;
            end
            CAU_DECREMENT_JUMP_NONZERO_OP: begin
                res_byte = dec_byte;
                res_valid = 1'b1;
                jump_d = dec_byte != 8'h00;
            end
            CAU_JUMP_SET_AND_CLEAR_OP: begin
                res_byte = dst_byte & ~bit_mask;
                res_valid = 1'b1;
                jump_d = dst_bit;
            end
            CAU_COMPLEMENT_OP: begin
                res_byte = dst_byte ^ bit_mask;
                res_valid = 1'b1;
            end
            CAU_CLEAR_BIT_OP: begin
                res_byte = dst_byte & ~bit_mask;
                res_valid = 1'b1;
            end
            CAU_SET_BIT_OP: begin
                res_byte = dst_byte | bit_mask;
                res_valid = 1'b1;
            end
            CAU_MOVE_CARRY_BIT_OP: begin
                res_byte = carry_q ? (dst_byte | bit_mask) : (dst_byte & ~bit_mask);
                res_valid = 1'b1;
            end
            CAU_READ_PIN_BYTE_OP: begin
                acc_d = pin_byte;
            end
            CAU_READ_PIN_BIT_OP: begin
                cy_d = pin_bit;
            end
            CAU_LOAD_B_OP: begin
                b_d = src_byte;
            end
            default: begin
                res_valid = 1'b0;
            end
        endcase
        // Byte results land in the latch or the accumulator, never both
        if (res_valid && !dst_port) begin
            acc_d = res_byte;
        end
    end

    wire wr_latch = fire && res_valid && dst_port;

    always_comb begin
        state_d = state_q;
        case (state_q)
            CAU_ST_IDLE: begin
                if (div_start) begin
                    state_d = CAU_ST_DIV;
                end
            end
            CAU_ST_DIV: begin
                if (div_done) begin
                    state_d = CAU_ST_IDLE;
                end
            end
            default: begin
                state_d = CAU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_q <= CAU_ST_IDLE;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= state_d == CAU_ST_IDLE;
        end
    end

    // Flags not written by an operation keep their values
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            acc_q <= CAU_BYTE_RST;
            b_q <= CAU_BYTE_RST;
            carry_q <= 1'b0;
            aux_carry_flag_q <= 1'b0;
            overflow_flag_q <= 1'b0;
        end else if (state_q == CAU_ST_DIV && div_done) begin
            acc_q <= div_quot;
            b_q <= div_rem;
            carry_q <= 1'b0;
            overflow_flag_q <= 1'b0;
        end else if (fire && !div_start) begin
            acc_q <= acc_d;
            b_q <= b_d;
            carry_q <= cy_d;
            aux_carry_flag_q <= ac_d;
            overflow_flag_q <= ov_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            port_latch_q <= CAU_LATCH_RST;
            jump_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (wr_latch) begin
                port_latch_q[{port_sel, 3'h0} +: 8] <= res_byte;
            end
            jump_q <= fire ? jump_d : (jump_q && !(state_q == CAU_ST_DIV));
            done_q <= (fire && !div_start) || (state_q == CAU_ST_DIV && div_done);
        end
    end

    add_carry_a:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
        fire && op_code == CAU_ADD_OP |=> {carry_q, acc_q} == $past({1'b0, acc_q} + {1'b0, src_byte}))
    else $error("add carry or sum wrong");

    add_with_carry_op_sum_a:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
        fire && op_code == CAU_ADD_WITH_CARRY_OP
        |=> acc_q == 8'($past(acc_q) + $past(src_byte) + {7'h00, $past(carry_q)}))
    else $error("add with carry sum wrong");

    add_overflow_a:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
        fire && (op_code == CAU_ADD_OP || op_code == CAU_ADD_WITH_CARRY_OP)
        |=> overflow_flag_q == (($past(acc_q[7]) == $past(src_byte[7])) && (acc_q[7] != $past(acc_q[7]))))
    else $error("add overflow wrong");

    subtract_borrow_op_borrow_a:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
        fire && op_code == CAU_SUBTRACT_BORROW_OP
        |=> carry_q == ($past({1'b0, acc_q}) < $past({1'b0, src_byte}) + {8'h00, $past(carry_q)}))
    else $error("subtract borrow wrong");

    mul_result_a:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
        fire && op_code == CAU_MULTIPLY_OP |=> {b_q, acc_q} == ({8'h00, $past(acc_q)} * {8'h00, $past(b_q)}))
    else $error("multiply product wrong");

    mul_flags_a:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
        fire && op_code == CAU_MULTIPLY_OP |=> !carry_q && (overflow_flag_q == (b_q != 8'h00)))
    else $error("multiply flags wrong");

    div_zero_a:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
        fire && op_code == CAU_DIVIDE_OP && div_zero |=> overflow_flag_q && !carry_q && done_q)
    else $error("divide by zero flags wrong");

    div_result_a:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
        div_start |=> !done_q [*8] ##2 (done_q && acc_q == $past(acc_q, 10) / $past(b_q, 10)
        && b_q == $past(acc_q, 10) % $past(b_q, 10) && !overflow_flag_q))
    else $error("divide result wrong");

    rotate_carry_a:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
        fire && op_code == CAU_ROTATE_RIGHT_CARRY_OP |=> {acc_q, carry_q} == $past({carry_q, acc_q}))
    else $error("rotate through carry wrong");

    port_setbit_a:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
        fire && dst_port && op_code == CAU_SET_BIT_OP
        |=> port_latch_q == ($past(port_latch_q) | (32'h0000_0001 << $past(bit_idx))))
    else $error("port bit set wrong");

    flags_keep_a:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
        fire && op_code == CAU_LOGICAL_XOR_OP |=> $stable(overflow_flag_q) && $stable(aux_carry_flag_q)
        && $stable(carry_q))
    else $error("unnamed flags changed");
endmodule : cau_alu_unit

// >>> verification/cau_alu_unit_tb.sv
// Purpose: self-checking bench for the accumulator arithmetic, flags and port read-modify-write
// Assumes: one-cycle ops answer with done_q set on the taking edge itself
// Notes: B starts at zero; the load-B op then gives multiply and divide real operands
`timescale 1ns/1ps
module tb
    import cau_pkg::*;
;
    logic sys_clk;
    logic rst_b;
    logic op_valid;
    logic [4:0] op_code;
    logic [7:0] src_byte;
    logic dst_port;
    logic [1:0] port_sel;
    logic [2:0] bit_sel;
    logic [CAU_PIN_W-1:0] pin_in;
    logic [7:0] acc_q;
    logic [7:0] b_q;
    logic carry_q;
    logic aux_carry_flag_q;
    logic overflow_flag_q;
    logic [CAU_PIN_W-1:0] port_latch_q;
    logic jump_q;
    logic done_q;
    logic ready_q;
    int fails;
    int total_checks;

    cau_alu_unit DUT (.sys_clk(sys_clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
        .src_byte(src_byte), .dst_port(dst_port), .port_sel(port_sel), .bit_sel(bit_sel), .pin_in(pin_in),
        .acc_q(acc_q), .b_q(b_q), .carry_q(carry_q), .aux_carry_flag_q(aux_carry_flag_q),
        .overflow_flag_q(overflow_flag_q), .port_latch_q(port_latch_q), .jump_q(jump_q), .done_q(done_q),
        .ready_q(ready_q));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Every wait is bounded; a hang ends the run as a mismatch
    task automatic do_op(input cau_op_t op, input logic [7:0] src, input logic dp, input logic [1:0] ps,
                         input logic [2:0] bs);
        int n;
        n = 0;
        while (ready_q !== 1'b1 || done_q === 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 30) begin
                fails++;
                tally_and_finish();
            end
        end
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op_code <= op;
        src_byte <= src;
        dst_port <= dp;
        port_sel <= ps;
        bit_sel <= bs;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
        n = 0;
        while (done_q !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 20) begin
                fails++;
                tally_and_finish();
            end
        end
    endtask : do_op

    task automatic acc_op(input cau_op_t op, input logic [7:0] src);
        do_op(op, src, 1'b0, 2'h0, 3'h0);
    endtask : acc_op

    // Logical ops leave the flags alone, so they can load the accumulator freely
    task automatic load_acc(input logic [7:0] v);
        acc_op(CAU_LOGICAL_AND_OP, 8'h00);
        acc_op(CAU_LOGICAL_OR_OP, v);
    endtask : load_acc

    task automatic set_carry(input logic c);
        load_acc({7'h00, c});
        acc_op(CAU_ROTATE_RIGHT_CARRY_OP, 8'h00);
    endtask : set_carry

    // Returns {carry, aux carry, overflow, result}
    function automatic logic [10:0] arith_ref(input cau_op_t op, input logic [7:0] a, input logic [7:0] b,
                                              input logic ci);
        logic [8:0] s;
        logic [7:0] s7;
        logic [4:0] s3;
        logic c_in;
        c_in = (op == CAU_ADD_OP) ? 1'b0 : ci;
        if (op == CAU_SUBTRACT_BORROW_OP) begin
            s = {1'b0, a} - {1'b0, b} - {8'h00, c_in};
            s7 = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, c_in};
            s3 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c_in};
        end else begin
            s = {1'b0, a} + {1'b0, b} + {8'h00, c_in};
            s7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, c_in};
            s3 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c_in};
        end
        return {s[8], s3[4], s7[7] ^ s[8], s[7:0]};
    endfunction : arith_ref

    task automatic t_reset();
        chk({b_q, acc_q}, 32'h0);
        chk({carry_q, aux_carry_flag_q, overflow_flag_q, jump_q, done_q, ready_q}, 32'h1);
        chk(port_latch_q, 32'hffffffff);
        $display("test reset done");
    endtask : t_reset

    task automatic t_arith();
        cau_op_t ops [3] = '{CAU_ADD_OP, CAU_ADD_WITH_CARRY_OP, CAU_SUBTRACT_BORROW_OP};
        logic [16:0] vec [6] = '{17'h13c48, 17'h07f01, 17'h18080, 17'h1ff00, 17'h00f01, 17'h050d0};
        logic [10:0] e;
        foreach (ops[i]) begin
            foreach (vec[j]) begin
                set_carry(vec[j][16]);
                load_acc(vec[j][15:8]);
                acc_op(ops[i], vec[j][7:0]);
                e = arith_ref(ops[i], vec[j][15:8], vec[j][7:0], vec[j][16]);
                chk(acc_q, e[7:0]);
                chk(carry_q, e[10]);
                chk(aux_carry_flag_q, e[9]);
                chk(overflow_flag_q, e[8]);
            end
        end
        $display("test arith done");
    endtask : t_arith

    task automatic t_muldiv();
        acc_op(CAU_ADD_OP, 8'h00);
        load_acc(8'h9c);
        acc_op(CAU_ADD_OP, 8'h78);
        acc_op(CAU_MULTIPLY_OP, 8'h00);
        chk({b_q, acc_q}, 32'h0);
        chk({carry_q, overflow_flag_q}, 32'h0);
        chk(aux_carry_flag_q, 1'b1);
        load_acc(8'h9c);
        acc_op(CAU_ADD_OP, 8'h78);
        acc_op(CAU_DIVIDE_OP, 8'h00);
        chk({b_q, acc_q}, 32'h0014);
        chk({carry_q, overflow_flag_q}, 32'h1);
        chk({aux_carry_flag_q, ready_q}, 32'h3);
        acc_op(CAU_LOAD_B_OP, 8'h0d);
        set_carry(1'b1);
        load_acc(8'hc8);
        acc_op(CAU_MULTIPLY_OP, 8'h00);
        chk({b_q, acc_q}, 32'h0a28);
        chk({carry_q, overflow_flag_q}, 32'h1);
        set_carry(1'b1);
        load_acc(8'hfb);
        acc_op(CAU_DIVIDE_OP, 8'h00);
        chk({b_q, acc_q}, 32'h0119);
        chk({carry_q, overflow_flag_q, aux_carry_flag_q}, 32'h1);
        $display("test multiply divide done");
    endtask : t_muldiv

    task automatic t_da();
        logic [15:0] vec [5] = '{16'h0908, 16'h4538, 16'h1234, 16'h8090, 16'h9999};
        logic [10:0] e;
        logic lo;
        logic [8:0] s;
        logic ov;
        foreach (vec[j]) begin
            load_acc(vec[j][15:8]);
            acc_op(CAU_ADD_OP, vec[j][7:0]);
            e = arith_ref(CAU_ADD_OP, vec[j][15:8], vec[j][7:0], 1'b0);
            ov = overflow_flag_q;
            lo = e[9] || (e[3:0] > CAU_DIGIT_MAX);
            s = {1'b0, e[7:0]} + (lo ? CAU_DA_LO : 9'h000) + ((e[10] || lo) ? CAU_DA_HI : 9'h000);
            acc_op(CAU_DECIMAL_ADJUST_OP, 8'h00);
            chk(acc_q, s[7:0]);
            chk(carry_q, s > CAU_BCD_MAX);
            chk({aux_carry_flag_q, overflow_flag_q}, {e[9], ov});
        end
        $display("test decimal adjust done");
    endtask : t_da

    task automatic t_rrc();
        logic [1:0] f;
        set_carry(1'b1);
        load_acc(8'h5a);
        f = {aux_carry_flag_q, overflow_flag_q};
        acc_op(CAU_ROTATE_RIGHT_CARRY_OP, 8'h00);
        chk({carry_q, acc_q}, 32'h0ad);
        acc_op(CAU_ROTATE_RIGHT_CARRY_OP, 8'h00);
        chk({carry_q, acc_q}, 32'h156);
        chk({aux_carry_flag_q, overflow_flag_q}, f);
        $display("test rotate done");
    endtask : t_rrc

    // Pins sit at zero while the latch holds ones, so a pin read would show up at once
    task automatic t_port();
        logic [24:0] tab [13] = '{{CAU_CLEAR_BIT_OP, 8'h00, 3'h3, 8'hf7, 1'b0},
            {CAU_CLEAR_BIT_OP, 8'h00, 3'h5, 8'hd7, 1'b0}, {CAU_SET_BIT_OP, 8'h00, 3'h3, 8'hdf, 1'b0},
            {CAU_MOVE_CARRY_BIT_OP, 8'h00, 3'h7, 8'h5f, 1'b0}, {CAU_COMPLEMENT_OP, 8'h00, 3'h0, 8'h5e, 1'b0},
            {CAU_JUMP_SET_AND_CLEAR_OP, 8'h00, 3'h1, 8'h5c, 1'b1},
            {CAU_JUMP_SET_AND_CLEAR_OP, 8'h00, 3'h1, 8'h5c, 1'b0},
            {CAU_LOGICAL_AND_OP, 8'hf0, 3'h0, 8'h50, 1'b0}, {CAU_LOGICAL_OR_OP, 8'h05, 3'h0, 8'h55, 1'b0},
            {CAU_LOGICAL_XOR_OP, 8'hff, 3'h0, 8'haa, 1'b0}, {CAU_INCREMENT_OP, 8'h00, 3'h0, 8'hab, 1'b0},
            {CAU_DECREMENT_OP, 8'h00, 3'h0, 8'haa, 1'b0},
            {CAU_DECREMENT_JUMP_NONZERO_OP, 8'h00, 3'h0, 8'ha9, 1'b1}};
        set_carry(1'b0);
        foreach (tab[i]) begin
            do_op(tab[i][24:20], tab[i][19:12], 1'b1, 2'h2, tab[i][11:9]);
            chk(port_latch_q, {8'hff, tab[i][8:1], 16'hffff});
            if (tab[i][24:20] == CAU_JUMP_SET_AND_CLEAR_OP || tab[i][24:20] == CAU_DECREMENT_JUMP_NONZERO_OP) begin
                chk(jump_q, tab[i][0]);
            end
        end
        $display("test port rmw done");
    endtask : t_port

    task automatic t_pin();
        @(posedge sys_clk);
        pin_in <= 32'h0000a500;
        repeat (6) @(posedge sys_clk);
        #1;
        do_op(CAU_READ_PIN_BYTE_OP, 8'h00, 1'b1, 2'h1, 3'h0);
        chk(acc_q, 8'ha5);
        do_op(CAU_READ_PIN_BIT_OP, 8'h00, 1'b1, 2'h1, 3'h1);
        chk(carry_q, 1'b0);
        do_op(CAU_READ_PIN_BIT_OP, 8'h00, 1'b1, 2'h1, 3'h0);
        chk(carry_q, 1'b1);
        chk(port_latch_q[15:8], 8'hff);
        $display("test pin read done");
    endtask : t_pin

    initial begin
        fails = 0;
        total_checks = 0;
        rst_b = 1'b0;
        op_valid = 1'b0;
        op_code = CAU_ADD_OP;
        src_byte = 8'h00;
        dst_port = 1'b0;
        port_sel = 2'h0;
        bit_sel = 3'h0;
        pin_in = '0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        t_reset();
        t_arith();
        t_muldiv();
        t_da();
        t_rrc();
        t_port();
        t_pin();
        tally_and_finish();
    end
endmodule : tb
